// ---- src/timer8_wave.sv ----
// Purpose: 8-bit timer waveform generation and compare output control
// Assumes: APB slave, single clock pclk
// Notes: tick is a count enable, logic fully synchronous
// Notes on behaviour
// - timer clock acts as count enable
// - nonzero A action routes A wave to pin; the code keeps the pin on port in modes 4 and 6
// - A non-PWM: off, toggle, clear, set
// - A fast PWM: toggle needs top bit
// - fast PWM cmp equal TOP ignored
// - A phase-correct: up/down clear or set
// - phase-correct cmp equal TOP acts at TOP
// - nonzero B action routes B wave to pin; the code keeps the pin on port in modes 4 and 6
// - B non-PWM: off, toggle, clear, set
// - B fast PWM code 01 reserved
// - B phase-correct code 01 reserved
// - bits 3:2 reserved, read zero, reset zero
// - mode from top bit and low bits
// - TOP source and compare update point
// - overflow flag point per mode
// - clock select picks prescale or pin
// - fast PWM wraps after TOP
// - flags clear by ack or write one
//
// The APB interface to the registers was chosen for this implementation.
module timer8_wave (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_clk_pin,
	input wire logic dir_a_out,
	input wire logic dir_b_out,
	input wire logic port_a_val,
	input wire logic port_b_val,
	input wire logic ack_ovf,
	input wire logic ack_match_a,
	input wire logic ack_match_b,
	output logic pin_a_o,
	output logic pin_a_oe_n,
	output logic pin_b_o,
	output logic pin_b_oe_n,
	output logic chan_a_wave_out,
	output logic chan_b_wave_out,
	output logic overflow_flag,
	output logic chan_a_match_flag,
	output logic chan_b_match_flag
);
	// ==========================================================
	// state and decoded signals
	// all state in one record, registered by a single process
	typedef struct packed {
		logic [7:0] timer_ctrl_a;
		logic [3:0] timer_ctrl_b;
		logic [7:0] count_value;
		logic [7:0] cmp_a_buf;
		logic [7:0] cmp_b_buf;
		logic [7:0] chan_a_compare_value;
		logic [7:0] chan_b_compare_value;
		logic count_down;
		logic wave_a;
		logic wave_b;
		logic ovf;
		logic mf_a;
		logic mf_b;
		logic eq_a;
		logic eq_b;
		logic block_cmp;
		logic ext_s1;
		logic ext_s2;
		logic [31:0] rdata;
	} state_t;
	state_t st_reg, st_next;
	logic tick;
	logic wr, rd;
	timer8_pkg::wave_mode_t mode;
	logic [7:0] top;
	logic [1:0] act_a, act_b;
	logic is_fast, is_pc, is_nonpwm, at_top, at_bottom, upd_now;
	logic cmp_hit_a, cmp_hit_b, ovf_set, next_dir_down;
	logic [7:0] cnt_next;
	logic [7:0] wdata8;
	// ==========================================================
	// count enable from prescaler or synchronised pin
	// the pin passes two flops here so tick_gen sees one clean domain
	// clock select
	tick_gen u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.clock_source_sel(st_reg.timer_ctrl_b[2:0]),
		.ext_sync(st_reg.ext_s2),
		.count_enable_tick(tick)
	);
	// ==========================================================
	// the waveform channel update, shared by A and B
	function automatic logic chan_wave(input logic cur, input logic [1:0] act,
		input logic hit, input logic topb, input logic fast, input logic pc,
		input logic down, input logic wrap, input logic ign, input logic at_t);
		logic r;
		r = cur;
		if (fast) begin
			// match ignored when cmp is TOP
			if (hit && !ign) begin
				if (act == 2'b01 && topb) r = ~cur;
				else if (act == 2'b10) r = 1'b0;
				else if (act == 2'b11) r = 1'b1;
			end
			if (wrap && act[1]) r = ~act[0];
		end else if (pc) begin
			// set or clear done at TOP
			if (ign && at_t && act[1]) r = ~act[0];
			else if (hit && !ign) begin
				if (act == 2'b01 && topb) r = ~cur;
				else if (act[1]) r = down ? ~act[0] : act[0];
			end
		end else if (hit) begin
			if (act == 2'b01) r = ~cur;
			else if (act[1]) r = act[0];
		end
		return r;
	endfunction
	// ==========================================================
	// mode decode
	always_comb begin
		// reserved modes 4 and 6 fall to the normal count path
		// mode value
		mode = timer8_pkg::wave_mode_t'({st_reg.timer_ctrl_b[timer8_pkg::top_sel_pos],
			st_reg.timer_ctrl_a[1:0]});
		act_a = st_reg.timer_ctrl_a[timer8_pkg::act_a_lsb +: 2];
		act_b = st_reg.timer_ctrl_a[timer8_pkg::act_b_lsb +: 2];
		is_fast = (mode == timer8_pkg::mode_fast_ff) || (mode == timer8_pkg::mode_fast_cmp);
		is_pc = (mode == timer8_pkg::mode_pc_ff) || (mode == timer8_pkg::mode_pc_cmp);
		is_nonpwm = (mode == timer8_pkg::mode_normal) || (mode == timer8_pkg::mode_ctc);
		if (mode == timer8_pkg::mode_ctc || mode == timer8_pkg::mode_pc_cmp ||
			mode == timer8_pkg::mode_fast_cmp) begin
			top = st_reg.chan_a_compare_value;
		end else begin
			top = timer8_pkg::max_val;
		end
		at_top = (st_reg.count_value == top);
		at_bottom = (st_reg.count_value == timer8_pkg::bottom_val);
	end
	// ==========================================================
	// apb decode; zero wait states
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign wdata8 = pwdata[7:0];
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~((paddr == timer8_pkg::ctrl_a_off) ||
		(paddr == timer8_pkg::ctrl_b_off) || (paddr == timer8_pkg::count_off) ||
		(paddr == timer8_pkg::cmp_a_off) || (paddr == timer8_pkg::cmp_b_off) ||
		(paddr == timer8_pkg::flags_off));
	// ==========================================================
	// next state
	always_comb begin
		st_next = st_reg;
		cmp_hit_a = 1'b0;
		cmp_hit_b = 1'b0;
		ovf_set = 1'b0;
		cnt_next = st_reg.count_value;
		next_dir_down = st_reg.count_down;
		upd_now = 1'b0;
		// two-flop sync, second flop feeds the edge detector
		st_next.ext_s1 = ext_clk_pin;
		st_next.ext_s2 = st_reg.ext_s1;
		if (tick) begin
			cmp_hit_a = st_reg.eq_a && !st_reg.block_cmp;
			cmp_hit_b = st_reg.eq_b && !st_reg.block_cmp;
			st_next.block_cmp = 1'b0;
			st_next.eq_a = 1'b0;
			st_next.eq_b = 1'b0;
			case (mode)
				timer8_pkg::mode_pc_ff, timer8_pkg::mode_pc_cmp: begin
					// direction turns at TOP, so TOP stands for one tick
					if (at_top) next_dir_down = 1'b1;
					else if (at_bottom) next_dir_down = 1'b0;
					cnt_next = next_dir_down ? st_reg.count_value - 8'h01
						: st_reg.count_value + 8'h01;
					ovf_set = at_bottom && st_reg.count_down;
					upd_now = at_top;
				end
				timer8_pkg::mode_fast_ff, timer8_pkg::mode_fast_cmp: begin
					// TOP stands for one tick before the wrap
					// wrap after TOP
					cnt_next = at_top ? timer8_pkg::bottom_val
						: st_reg.count_value + 8'h01;
					ovf_set = at_top;
					upd_now = at_top;
				end
				timer8_pkg::mode_ctc: begin
					// overflow only if TOP happens to be MAX
					cnt_next = at_top ? timer8_pkg::bottom_val
						: st_reg.count_value + 8'h01;
					ovf_set = (st_reg.count_value == timer8_pkg::max_val);
				end
				default: begin
					// reserved modes run the counter but raise no overflow
					// reserved modes count as normal
					cnt_next = st_reg.count_value + 8'h01;
					ovf_set = (st_reg.count_value == timer8_pkg::max_val) &&
						(mode == timer8_pkg::mode_normal);
				end
			endcase
			st_next.count_value = cnt_next;
			st_next.count_down = next_dir_down;
			st_next.wave_a = chan_wave(st_reg.wave_a, act_a, cmp_hit_a,
				mode[2], is_fast, is_pc, st_reg.count_down, at_top && is_fast,
				st_reg.chan_a_compare_value == top, at_top);
			// B code 01 never toggles in PWM
			st_next.wave_b = chan_wave(st_reg.wave_b, act_b, cmp_hit_b,
				1'b0, is_fast, is_pc, st_reg.count_down, at_top && is_fast,
				st_reg.chan_b_compare_value == top, at_top);
		end else begin
			st_next.eq_a = st_reg.eq_a | (st_reg.count_value == st_reg.chan_a_compare_value);
			st_next.eq_b = st_reg.eq_b | (st_reg.count_value == st_reg.chan_b_compare_value);
		end
		// equality is remembered between ticks so a prescaled
		// match is flagged on the tick that follows it
		if (tick) begin
			st_next.eq_a = (cnt_next == st_reg.chan_a_compare_value);
			st_next.eq_b = (cnt_next == st_reg.chan_b_compare_value);
		end
		// PWM modes wait for TOP so that one period
		// never sees two compare values
		// immediate update outside PWM
		if (is_nonpwm || !(is_fast || is_pc) || upd_now) begin
			st_next.chan_a_compare_value = st_reg.cmp_a_buf;
			st_next.chan_b_compare_value = st_reg.cmp_b_buf;
		end
		// ==========================================================
		// sticky flags
		// flags: set wins over clear
		st_next.ovf = ovf_set | (st_reg.ovf & ~ack_ovf &
			~(wr && paddr == timer8_pkg::flags_off && wdata8[0]));
		st_next.mf_a = cmp_hit_a | (st_reg.mf_a & ~ack_match_a &
			~(wr && paddr == timer8_pkg::flags_off && wdata8[1]));
		st_next.mf_b = cmp_hit_b | (st_reg.mf_b & ~ack_match_b &
			~(wr && paddr == timer8_pkg::flags_off && wdata8[2]));
		// ==========================================================
		// register writes
		if (wr) begin
			if (paddr == timer8_pkg::ctrl_a_off) begin
				st_next.timer_ctrl_a = wdata8 & timer8_pkg::ctrl_a_mask;
			end else if (paddr == timer8_pkg::ctrl_b_off) begin
				st_next.timer_ctrl_b = wdata8[3:0];
				// force strobes act only in normal and CTC modes, no flag
				if (is_nonpwm && wdata8[7]) begin
					st_next.wave_a = chan_wave(st_reg.wave_a, act_a, 1'b1,
						1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
				end
				if (is_nonpwm && wdata8[6]) begin
					st_next.wave_b = chan_wave(st_reg.wave_b, act_b, 1'b1,
						1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
				end
			end else if (paddr == timer8_pkg::count_off) begin
				// writing the counter mid-run can miss a match;
				// software has to live with that
				// a counter write blocks a match on the next tick only
				st_next.count_value = wdata8;
				st_next.block_cmp = 1'b1;
				st_next.eq_a = 1'b0;
				st_next.eq_b = 1'b0;
			end else if (paddr == timer8_pkg::cmp_a_off) begin
				st_next.cmp_a_buf = wdata8;
			end else if (paddr == timer8_pkg::cmp_b_off) begin
				st_next.cmp_b_buf = wdata8;
			end
		end
		// ==========================================================
		// read data captured in setup, held for access
		if (rd) begin
			if (paddr == timer8_pkg::ctrl_a_off) begin
				st_next.rdata = {24'h000000, st_reg.timer_ctrl_a};
			end else if (paddr == timer8_pkg::ctrl_b_off) begin
				st_next.rdata = {28'h0000000, st_reg.timer_ctrl_b};
			end else if (paddr == timer8_pkg::count_off) begin
				st_next.rdata = {24'h000000, st_reg.count_value};
			end else if (paddr == timer8_pkg::cmp_a_off) begin
				st_next.rdata = {24'h000000, st_reg.cmp_a_buf};
			end else if (paddr == timer8_pkg::cmp_b_off) begin
				st_next.rdata = {24'h000000, st_reg.cmp_b_buf};
			end else if (paddr == timer8_pkg::flags_off) begin
				st_next.rdata = {29'h00000000, st_reg.mf_b, st_reg.mf_a, st_reg.ovf};
			end else begin
				st_next.rdata = 32'h00000000;
			end
		end
	end
	// ==========================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	// ==========================================================
	// outputs
	// data outputs come straight from flip-flops
	assign prdata = st_reg.rdata;
	assign chan_a_wave_out = st_reg.wave_a;
	assign chan_b_wave_out = st_reg.wave_b;
	assign overflow_flag = st_reg.ovf;
	assign chan_a_match_flag = st_reg.mf_a;
	assign chan_b_match_flag = st_reg.mf_b;
	// the mux is combinational, so the pin follows a mode write at once
	// A routed when action nonzero and mode is not 4 or 6
	// reserved action code leaves pin on port
	always_comb begin
		if (act_a != 2'b00 && !(act_a == 2'b01 && !is_nonpwm && !mode[2]) &&
			mode != timer8_pkg::mode_res4 && mode != timer8_pkg::mode_res6) begin
			pin_a_o = st_reg.wave_a;
		end else begin
			pin_a_o = port_a_val;
		end
		if (act_b != 2'b00 && !(act_b == 2'b01 && !is_nonpwm) &&
			mode != timer8_pkg::mode_res4 && mode != timer8_pkg::mode_res6) begin
			pin_b_o = st_reg.wave_b;
		end else begin
			pin_b_o = port_b_val;
		end
		pin_a_oe_n = ~dir_a_out;
		pin_b_oe_n = ~dir_b_out;
	end
endmodule // timer8_wave

// ---- src/timer8_pkg.sv ----
// Purpose: shared constants for the 8-bit timer waveform block
// Assumes: 32-bit APB, one register per aligned word
// Notes: offsets are byte addresses
package timer8_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] ctrl_a_off = 8'h30;
	localparam logic [7:0] ctrl_b_off = 8'h34;
	localparam logic [7:0] count_off = 8'h38;
	localparam logic [7:0] cmp_a_off = 8'h3C;
	localparam logic [7:0] cmp_b_off = 8'h40;
	localparam logic [7:0] flags_off = 8'h44;
	// ==========================================================
	// field positions and masks
	localparam logic [7:0] ctrl_a_mask = 8'hF3;
	localparam logic [7:0] ctrl_b_mask = 8'h0F;
	localparam int act_a_lsb = 6;
	localparam int act_b_lsb = 4;
	localparam int top_sel_pos = 3;
	localparam logic [7:0] reset_byte = 8'h00;
	localparam logic [7:0] max_val = 8'hFF;
	localparam logic [7:0] bottom_val = 8'h00;
	// ==========================================================
	// prescaler divide counts
	localparam int presc_w = 10;
	localparam logic [9:0] div8_last = 10'h007;
	localparam logic [9:0] div64_last = 10'h03F;
	localparam logic [9:0] div256_last = 10'h0FF;
	localparam logic [9:0] div1024_last = 10'h3FF;
	// ==========================================================
	// waveform modes
	typedef enum logic [2:0] {
		mode_normal = 3'b000,
		mode_pc_ff = 3'b001,
		mode_ctc = 3'b010,
		mode_fast_ff = 3'b011,
		mode_res4 = 3'b100,
		mode_pc_cmp = 3'b101,
		mode_res6 = 3'b110,
		mode_fast_cmp = 3'b111
	} wave_mode_t;
endpackage

// ---- src/tick_gen.sv ----
// Purpose: timer count enable from prescaler or external pin
// Assumes: ext pin already synchronised by the caller
// Notes: one-cycle tick, never a clock
module tick_gen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] clock_source_sel,
	input wire logic ext_sync,
	output logic count_enable_tick
);
	typedef struct packed {
		logic [9:0] presc;
		logic ext_prev;
	} tick_state_t;
	tick_state_t st_reg, st_next;
	logic hit;
	// ==========================================================
	// prescaler and edge detect
	always_comb begin
		st_next = st_reg;
		st_next.presc = st_reg.presc + 10'h001;
		st_next.ext_prev = ext_sync;
		case (clock_source_sel)
			3'b001: hit = 1'b1;
			3'b010: hit = (st_reg.presc[2:0] == timer8_pkg::div8_last[2:0]);
			3'b011: hit = (st_reg.presc[5:0] == timer8_pkg::div64_last[5:0]);
			3'b100: hit = (st_reg.presc[7:0] == timer8_pkg::div256_last[7:0]);
			3'b101: hit = (st_reg.presc == timer8_pkg::div1024_last);
			// falling edge of the pin
			3'b110: hit = st_reg.ext_prev & ~ext_sync;
			3'b111: hit = ~st_reg.ext_prev & ext_sync;
			default: hit = 1'b0; // stopped
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign count_enable_tick = hit;
endmodule // tick_gen

// ---- test/timer8_wave_chk.sv ----
// Purpose: port-level assertions for the 8-bit timer waveform block
// Assumes: zero-wait APB, control fields shadowed from writes seen on the bus
// Notes: bound to timer8_wave at the foot of this file
module timer8_wave_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dir_a_out,
	input wire logic port_a_val,
	input wire logic port_b_val,
	input wire logic ack_ovf,
	input wire logic ack_match_a,
	input wire logic pin_a_o,
	input wire logic pin_a_oe_n,
	input wire logic pin_b_o,
	input wire logic chan_a_wave_out,
	input wire logic overflow_flag,
	input wire logic chan_a_match_flag
);
	// ==========================================================
	// shadow of control writes, so pin routing can be judged
	typedef struct packed {
		logic [7:0] ctrl_a_reg;
		logic [7:0] ctrl_b_reg;
	} shadow_t;
	shadow_t cur_reg;
	shadow_t cur_next;
	logic wr_hit, clr_ovf_w, clr_mta_w, cs_zero, mapped;
	logic [2:0] mode;
	logic [1:0] act_a, act_b;
	// decoded helpers; force strobes are masked out of the shadow
	assign wr_hit = psel && penable && pwrite && pready;
	assign clr_ovf_w = wr_hit && paddr == timer8_pkg::flags_off && pwdata[0];
	assign clr_mta_w = wr_hit && paddr == timer8_pkg::flags_off && pwdata[1];
	assign mode = {cur_reg.ctrl_b_reg[3], cur_reg.ctrl_a_reg[1:0]};
	assign act_a = cur_reg.ctrl_a_reg[7:6];
	assign act_b = cur_reg.ctrl_a_reg[5:4];
	assign cs_zero = cur_reg.ctrl_b_reg[2:0] == 3'h0;
	assign mapped = paddr inside {8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44};
	always_comb begin
		cur_next = cur_reg;
		if (wr_hit && paddr == timer8_pkg::ctrl_a_off) begin
			cur_next.ctrl_a_reg = pwdata[7:0] & timer8_pkg::ctrl_a_mask;
		end
		if (wr_hit && paddr == timer8_pkg::ctrl_b_off) begin
			cur_next.ctrl_b_reg = pwdata[7:0] & timer8_pkg::ctrl_b_mask;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// properties
	// a few cycles of stopped clock select, so no tick is still in flight
	sequence stopped_s;
		cs_zero [*3];
	endsequence
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_slverr_unmapped: assert property (psel && penable && !mapped |-> pslverr)
		else $error("no error on unmapped access");
	a_oe_follows_dir: assert property (pin_a_oe_n == !dir_a_out)
		else $error("pin A enable does not follow direction");
	a_pin_a_port: assert property (act_a == 2'h0 || mode[1:0] == 2'h0 && mode[2] |-> pin_a_o == port_a_val)
		else $error("pin A not on port value");
	a_pin_a_wave: assert property (act_a != 2'h0 && !mode[2] && !mode[0] |-> pin_a_o == chan_a_wave_out)
		else $error("pin A not on waveform");
	a_pin_b_resv: assert property (mode[0] && act_b == 2'h1 |-> pin_b_o == port_b_val)
		else $error("reserved B code drives waveform");
	a_read_ctrl_a: assert property (psel && penable && !pwrite && paddr == timer8_pkg::ctrl_a_off |-> prdata == {24'h0, cur_reg.ctrl_a_reg})
		else $error("control A read value wrong");
	a_ovf_clear_cause: assert property ($fell(overflow_flag) |-> $past(ack_ovf) || $past(clr_ovf_w))
		else $error("overflow flag fell without cause");
	a_match_clear_cause: assert property ($fell(chan_a_match_flag) |-> $past(ack_match_a) || $past(clr_mta_w))
		else $error("match A flag fell without cause");
	a_stopped_quiet: assert property (stopped_s |=> !$rose(overflow_flag) && !$rose(chan_a_match_flag))
		else $error("flag rose with counter stopped");
endmodule // timer8_wave_chk

bind timer8_wave timer8_wave_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .dir_a_out(dir_a_out), .port_a_val(port_a_val),
	.port_b_val(port_b_val), .ack_ovf(ack_ovf), .ack_match_a(ack_match_a), .pin_a_o(pin_a_o),
	.pin_a_oe_n(pin_a_oe_n), .pin_b_o(pin_b_o), .chan_a_wave_out(chan_a_wave_out),
	.overflow_flag(overflow_flag), .chan_a_match_flag(chan_a_match_flag));

// ---- test/tb_timer8_waveform_mode_control.sv ----
// Purpose: self-checking bench for the timer waveform block over APB
// Assumes: clock select 001 gives one tick per cycle
// Notes: outputs are sampled at the falling edge, after updates settle
module tb_timer8_waveform_mode_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ext_clk_pin;
	logic dir_a_out, dir_b_out, port_a_val, port_b_val, ack_ovf, ack_match_a, ack_match_b;
	logic pin_a_o, pin_a_oe_n, pin_b_o, pin_b_oe_n, chan_a_wave_out, chan_b_wave_out;
	logic overflow_flag, chan_a_match_flag, chan_b_match_flag;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int n_mismatch, total_checks;
	timer8_wave uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_clk_pin(ext_clk_pin), .dir_a_out(dir_a_out),
		.dir_b_out(dir_b_out), .port_a_val(port_a_val), .port_b_val(port_b_val),
		.ack_ovf(ack_ovf), .ack_match_a(ack_match_a), .ack_match_b(ack_match_b),
		.pin_a_o(pin_a_o), .pin_a_oe_n(pin_a_oe_n), .pin_b_o(pin_b_o), .pin_b_oe_n(pin_b_oe_n),
		.chan_a_wave_out(chan_a_wave_out), .chan_b_wave_out(chan_b_wave_out),
		.overflow_flag(overflow_flag), .chan_a_match_flag(chan_a_match_flag),
		.chan_b_match_flag(chan_b_match_flag));
	// ==========================================================
	// clock, checking and closing
	always #10 pclk = ~pclk;
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ==========================================================
	// bus tasks: request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge pclk);
	endtask
	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	// hang guard, far beyond the roughly 700 cycles the run needs
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		stop_test();
	end
	// ==========================================================
	// main sequence
	initial begin
		logic [2:0] exp_w;
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		ext_clk_pin = 0; dir_a_out = 1; dir_b_out = 1; port_a_val = 0; port_b_val = 0;
		ack_ovf = 0; ack_match_a = 0; ack_match_b = 0; n_mismatch = 0; total_checks = 0;
		exp_w = 3'b101;
		do_reset();
		apb(0, timer8_pkg::ctrl_a_off, 0);
		check("ctrl_a reset", q, 32'h00000000);
		apb(1, timer8_pkg::ctrl_a_off, 32'hFFFFFFFF);
		apb(0, timer8_pkg::ctrl_a_off, 0);
		check("ctrl_a reserved", q, {24'h0, timer8_pkg::ctrl_a_mask});
		apb(0, 8'h48, 0);
		check("unmapped error", err, 1);
		// non-PWM codes on both channels: toggle, clear, set
		apb(1, timer8_pkg::ctrl_a_off, 0);
		apb(1, timer8_pkg::cmp_a_off, 32'h10);
		apb(1, timer8_pkg::cmp_b_off, 32'h10);
		apb(1, timer8_pkg::ctrl_b_off, 32'h01);
		for (int k = 1; k < 4; k++) begin
			apb(1, timer8_pkg::ctrl_a_off, {24'h0, k[1:0], k[1:0], 4'h0});
			apb(1, timer8_pkg::count_off, 32'h08);
			apb(1, timer8_pkg::flags_off, 32'h06);
			cyc(10);
			check("wave A code", chan_a_wave_out, exp_w[k-1]);
			check("wave B code", chan_b_wave_out, exp_w[k-1]);
			check("match A flag", chan_a_match_flag, 1);
			check("match B flag", chan_b_match_flag, 1);
		end
		@(posedge pclk);
		ack_match_a <= 1'b1;
		@(posedge pclk);
		ack_match_a <= 1'b0;
		cyc(1);
		check("ack clears match A", chan_a_match_flag, 0);
		apb(1, timer8_pkg::count_off, 32'hFC);
		cyc(8);
		check("overflow at max", overflow_flag, 1);
		apb(1, timer8_pkg::flags_off, 32'h01);
		cyc(1);
		check("write one clears ovf", overflow_flag, 0);
		// prescaled count: divide by 8
		apb(1, timer8_pkg::ctrl_b_off, 32'h02);
		apb(1, timer8_pkg::count_off, 32'h00);
		cyc(80);
		apb(0, timer8_pkg::count_off, 0);
		check("div8 count", q >= 32'h9 && q <= 32'hB, 1);
		// clear-on-match: TOP is the A compare, so no overflow
		apb(1, timer8_pkg::ctrl_a_off, 32'h02);
		apb(1, timer8_pkg::count_off, 32'h00);
		apb(1, timer8_pkg::ctrl_b_off, 32'h01);
		apb(1, timer8_pkg::flags_off, 32'h07);
		cyc(300);
		check("ctc no overflow", overflow_flag, 0);
		check("ctc match A", chan_a_match_flag, 1);
		// fast PWM, codes 10 and 11 on both channels
		for (int k = 2; k < 4; k++) begin
			apb(1, timer8_pkg::ctrl_a_off, {24'h0, k[1:0], k[1:0], 4'h3});
			apb(1, timer8_pkg::count_off, 32'hFA);
			cyc(10);
			check("fast A bottom", chan_a_wave_out, k == 2);
			check("fast B bottom", chan_b_wave_out, k == 2);
			cyc(20);
			check("fast A match", chan_a_wave_out, k == 3);
			check("fast B match", chan_b_wave_out, k == 3);
		end
		apb(1, timer8_pkg::ctrl_a_off, 32'h53);
		cyc(2);
		check("fast A 01 no top bit", pin_a_o, port_a_val);
		check("fast B 01 reserved", pin_b_o, port_b_val);
		// second reset, then phase-correct from a known up direction
		do_reset();
		apb(1, timer8_pkg::cmp_a_off, 32'hF0);
		apb(1, timer8_pkg::cmp_b_off, 32'hF0);
		apb(1, timer8_pkg::ctrl_a_off, 32'hB1);
		apb(1, timer8_pkg::count_off, 32'hE8);
		apb(1, timer8_pkg::ctrl_b_off, 32'h01);
		cyc(16);
		check("pc A up", chan_a_wave_out, 0);
		check("pc B up", chan_b_wave_out, 1);
		cyc(30);
		check("pc A down", chan_a_wave_out, 1);
		check("pc B down", chan_b_wave_out, 0);
		check("pc no ovf at top", overflow_flag, 0);
		// reserved mode 4 leaves both pins on the port
		apb(1, timer8_pkg::ctrl_a_off, 32'hB0);
		apb(1, timer8_pkg::ctrl_b_off, 32'h09);
		port_b_val <= 1'b1;
		dir_b_out <= 1'b0;
		cyc(2);
		check("mode4 pin A", pin_a_o, port_a_val);
		check("mode4 pin B", pin_b_o, 1);
		check("pin B enable off", pin_b_oe_n, 1);
		stop_test();
	end
endmodule // tb_timer8_waveform_mode_control
